//--- include/cpp_pkg.sv
/*
 Shared constants for the channel 9 to 12 digital post-processing slice.
 Assumes a 32-bit APB master; each register takes one aligned word.
*/
package cpp_pkg;
   // ----------------------------------------
   // Register indices, byte address is index times four
   // ----------------------------------------
   localparam logic [5:0] IDX_GLOBAL_CFG = 6'h03;
   localparam logic [5:0] IDX_PATTERN_CFG = 6'h04;
   localparam logic [5:0] IDX_CH12_GAIN_OFS = 6'h2b;
   localparam logic [5:0] IDX_CH12_OFS_COPY = 6'h2c;
   localparam logic [5:0] IDX_PAT_HPF = 6'h2d;
   localparam logic [5:0] IDX_STATUS = 6'h3e;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // Reserved bits are never stored, so they read back as zero
   localparam logic [15:0] MASK_GAIN_OFS = 16'hfbff;
   localparam logic [15:0] MASK_OFS_COPY = 16'h03ff;
   localparam logic [15:0] MASK_PAT_HPF = 16'hffdf;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int GAIN_ON_BIT = 12;
   localparam int OFFSET_ON_BIT = 8;
   localparam int PAT_MODE_BIT = 8;
   localparam int GAIN_LSB = 11;
   localparam int GAIN_W = 5;
   localparam int OFS_W = 10;
   localparam int PRBS9_BIT = 15;
   localparam int PAT9_LSB = 9;
   localparam int PAT10_LSB = 6;
   localparam int K_LSB = 1;
   localparam int HPF_ON_BIT = 0;
   localparam logic [3:0] K_MIN = 4'h2;
   localparam logic [3:0] K_MAX = 4'ha;
   // ----------------------------------------
   // Datapath constants
   // ----------------------------------------
   localparam int GAIN_FRAC = 10;
   localparam logic [14:0] PRBS_SEED = 15'h7fff;
   typedef enum logic [2:0] {
      PAT_NORMAL = 3'h0,
      PAT_ZEROS = 3'h1,
      PAT_ONES = 3'h2,
      PAT_TOGGLE = 3'h3,
      PAT_RAMP = 3'h4
   } cpp_pattern_e;
   // Gain of N x 0.2 dB as an unsigned factor with ten fraction bits
   localparam logic [11:0] GAIN_Q10 [32] = '{
      12'h400, 12'h418, 12'h430, 12'h449, 12'h463, 12'h47d, 12'h498, 12'h4b3,
      12'h4cf, 12'h4ec, 12'h509, 12'h527, 12'h546, 12'h565, 12'h586, 12'h5a6,
      12'h5c8, 12'h5eb, 12'h60e, 12'h632, 12'h657, 12'h67d, 12'h6a3, 12'h6cb,
      12'h6f4, 12'h71d, 12'h747, 12'h773, 12'h79f, 12'h7cd, 12'h7fb, 12'h82b};
endpackage

//--- hdl/cpp_chan_postproc.sv
/*
 Digital post-processing for channels 9 to 12: channel 12 gain and offset,
 shared high-pass filter, and per-lane pattern and PRBS serial output.
 Assumes samples arrive on mclk from the ADC side and an APB master.
*/
// Chosen here: register access over APB.
// Contract
// - Channel 12 is scaled by its five-bit gain field times 0.2 dB.
// - Channel 12 gain applies only while the global gain enable is set.
// - Channel 12 adds a ten-bit signed offset only while offset enable is set.
// - Four PRBS bits pick PRBS per lane, only in per-lane pattern mode.
// - Per-lane mode: three-bit fields pick test patterns for lanes 9 and 10.
// - One bit enables the high-pass filter for all four channels; default off.
// - Filter k comes from a four-bit field and stays between 2 and 10.
// - Filter computes y = 2^k/(2^k+1) times (x(n) - x(n-1) + y(n-1)).
// - The gain and first offset copy register decodes at index 2Bh.
module cpp_chan_postproc #(
   parameter int SW = 14,
   parameter int FB = 8
) (
   input logic mclk,
   input logic reset_n,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input logic sample_valid,
   input logic signed [SW-1:0] sample_ch9,
   input logic signed [SW-1:0] sample_ch10,
   input logic signed [SW-1:0] sample_ch11,
   input logic signed [SW-1:0] sample_ch12,
   output logic [3:0] lane_data,
   output logic lane_frame
);
   localparam int WW = SW + 14;
   localparam int HW = SW + FB + 3;
   localparam int FL = SW;

   if (SW < 12 || SW > 16 || FB < 4 || FB > 12)
   begin : g_bad_param
      $error("cpp_chan_postproc: SW must be 12..16 and FB 4..12");
   end

   function automatic logic signed [SW-1:0] sat(input logic signed [WW-1:0] v);
      logic signed [WW-1:0] hi;
      logic signed [WW-1:0] lo;
      hi = WW'((1 << (SW - 1)) - 1);
      lo = -hi - WW'(1);
      if (v > hi)
         return hi[SW-1:0];
      else if (v < lo)
         return lo[SW-1:0];
      else
         return v[SW-1:0];
   endfunction

   // ----------------------------------------
   // Register file over APB
   // ----------------------------------------
   logic global_gain_on, next_global_gain_on;
   logic global_offset_on, next_global_offset_on;
   logic per_lane_pattern_mode, next_per_lane_pattern_mode;
   logic [15:0] reg_go, next_reg_go;
   logic [15:0] reg_oc, next_reg_oc;
   logic [15:0] reg_ph, next_reg_ph;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic signed [SW-1:0] out [4];
   logic [5:0] idx;
   logic wr, hit;
   logic [15:0] rd;

   assign idx = paddr[7:2];
   assign wr = psel && penable && pready && pwrite;

   always_comb
   begin
      next_global_gain_on = global_gain_on;
      next_global_offset_on = global_offset_on;
      next_per_lane_pattern_mode = per_lane_pattern_mode;
      next_reg_go = reg_go;
      next_reg_oc = reg_oc;
      next_reg_ph = reg_ph;
      hit = paddr[1:0] == 2'h0;
      rd = 16'h0000;
      if (idx == cpp_pkg::IDX_GLOBAL_CFG)
      begin
         rd[cpp_pkg::GAIN_ON_BIT] = global_gain_on;
         rd[cpp_pkg::OFFSET_ON_BIT] = global_offset_on;
      end
      else if (idx == cpp_pkg::IDX_PATTERN_CFG)
         rd[cpp_pkg::PAT_MODE_BIT] = per_lane_pattern_mode;
      else if (idx == cpp_pkg::IDX_CH12_GAIN_OFS)
         rd = reg_go;
      else if (idx == cpp_pkg::IDX_CH12_OFS_COPY)
         rd = reg_oc;
      else if (idx == cpp_pkg::IDX_PAT_HPF)
         rd = reg_ph;
      else if (idx == cpp_pkg::IDX_STATUS)
         rd = 16'(unsigned'(out[3]));
      else
         hit = 1'b0;
      // Writes land only on the access edge; reserved bits are masked off
      if (wr && hit)
      begin
         if (idx == cpp_pkg::IDX_GLOBAL_CFG)
         begin
            next_global_gain_on = pwdata[cpp_pkg::GAIN_ON_BIT];
            next_global_offset_on = pwdata[cpp_pkg::OFFSET_ON_BIT];
         end
         else if (idx == cpp_pkg::IDX_PATTERN_CFG)
            next_per_lane_pattern_mode = pwdata[cpp_pkg::PAT_MODE_BIT];
         else if (idx == cpp_pkg::IDX_CH12_GAIN_OFS)
            next_reg_go = pwdata[15:0] & cpp_pkg::MASK_GAIN_OFS;
         else if (idx == cpp_pkg::IDX_CH12_OFS_COPY)
            next_reg_oc = pwdata[15:0] & cpp_pkg::MASK_OFS_COPY;
         else if (idx == cpp_pkg::IDX_PAT_HPF)
            next_reg_ph = pwdata[15:0] & cpp_pkg::MASK_PAT_HPF;
      end
      // One access cycle: answer registered in the setup cycle
      next_pready = psel && !penable;
      next_pslverr = next_pready && !hit;
      next_prdata = (next_pready && hit) ? {16'h0000, rd} : 32'h00000000;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         global_gain_on <= 1'b0;
         global_offset_on <= 1'b0;
         per_lane_pattern_mode <= 1'b0;
         reg_go <= cpp_pkg::REG_RESET;
         reg_oc <= cpp_pkg::REG_RESET;
         reg_ph <= cpp_pkg::REG_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         global_gain_on <= next_global_gain_on;
         global_offset_on <= next_global_offset_on;
         per_lane_pattern_mode <= next_per_lane_pattern_mode;
         reg_go <= next_reg_go;
         reg_oc <= next_reg_oc;
         reg_ph <= next_reg_ph;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------
   // Channel 12 gain and offset, then shared high-pass filter
   // ----------------------------------------
   logic signed [SW-1:0] s1 [4], next_s1 [4], next_out [4];
   logic signed [HW-1:0] xp [4], yp [4], next_xp [4], next_yp [4];
   logic v1, next_v1, hpf_on;
   logic [3:0] k_raw, k_eff;
   logic signed [WW-1:0] prod, gained, ofs_sx;
   logic signed [HW-1:0] xq, acc, yv;

   assign hpf_on = reg_ph[cpp_pkg::HPF_ON_BIT];
   assign k_raw = reg_ph[cpp_pkg::K_LSB +: 4];
   assign k_eff = k_raw < cpp_pkg::K_MIN ? cpp_pkg::K_MIN : (k_raw > cpp_pkg::K_MAX ? cpp_pkg::K_MAX : k_raw);
   // Offset is taken from the gain register copy; the other copy must match
   assign ofs_sx = WW'(signed'(reg_go[cpp_pkg::OFS_W-1:0]));

   always_comb
   begin
      xq = '0;
      acc = '0;
      yv = '0;
      next_v1 = sample_valid;
      next_s1 = s1;
      next_xp = xp;
      next_yp = yp;
      next_out = out;
      prod = WW'(sample_ch12) * WW'(signed'({1'b0, cpp_pkg::GAIN_Q10[reg_go[cpp_pkg::GAIN_LSB +: cpp_pkg::GAIN_W]]}));
      gained = global_gain_on ? (prod >>> cpp_pkg::GAIN_FRAC) : WW'(sample_ch12);
      if (sample_valid)
      begin
         next_s1[0] = sample_ch9;
         next_s1[1] = sample_ch10;
         next_s1[2] = sample_ch11;
         next_s1[3] = sat(gained + (global_offset_on ? ofs_sx : WW'(0)));
      end
      if (v1)
      begin
         for (int i = 0; i < 4; i++)
         begin
            xq = HW'(s1[i]) <<< FB;
            acc = xq - xp[i] + yp[i];
            // Series for 2^k/(2^k+1); relative error below 2^-4k
            yv = acc - (acc >>> k_eff) + (acc >>> (2 * k_eff)) - (acc >>> (3 * k_eff));
            next_xp[i] = xq;
            next_yp[i] = hpf_on ? yv : HW'(0);
            next_out[i] = hpf_on ? sat(WW'(yv >>> FB)) : s1[i];
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         v1 <= 1'b0;
         s1 <= '{default: '0};
         out <= '{default: '0};
         xp <= '{default: '0};
         yp <= '{default: '0};
      end
      else
      begin
         v1 <= next_v1;
         s1 <= next_s1;
         out <= next_out;
         xp <= next_xp;
         yp <= next_yp;
      end
   end

   // ----------------------------------------
   // Serial lanes: free-running word frames, MSB first
   // ----------------------------------------
   logic [4:0] cnt, next_cnt;
   logic [SW-1:0] sh [4], next_sh [4], ramp, next_ramp;
   logic [14:0] lfsr, next_lfsr;
   logic [3:0] prbs_q, next_prbs_q, next_lane_data;
   logic next_lane_frame;
   cpp_pkg::cpp_pattern_e sel;
   logic [SW-1:0] word;

   always_comb
   begin
      sel = cpp_pkg::PAT_NORMAL;
      word = '0;
      next_cnt = (cnt == 5'(SW - 1)) ? 5'h00 : cnt + 5'h01;
      next_lane_frame = next_cnt == 5'h00;
      next_lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      next_ramp = next_lane_frame ? ramp + SW'(1) : ramp;
      next_prbs_q = prbs_q;
      for (int i = 0; i < 4; i++)
      begin
         sel = cpp_pkg::PAT_NORMAL;
         if (per_lane_pattern_mode && i == 0)
            sel = cpp_pkg::cpp_pattern_e'(reg_ph[cpp_pkg::PAT9_LSB +: 3]);
         else if (per_lane_pattern_mode && i == 1)
            sel = cpp_pkg::cpp_pattern_e'(reg_ph[cpp_pkg::PAT10_LSB +: 3]);
         case (sel)
            cpp_pkg::PAT_ZEROS: word = '0;
            cpp_pkg::PAT_ONES: word = '1;
            cpp_pkg::PAT_TOGGLE: word = {SW{ramp[0]}};
            cpp_pkg::PAT_RAMP: word = ramp;
            default: word = out[i];
         endcase
         next_sh[i] = next_lane_frame ? word : {sh[i][SW-2:0], 1'b0};
         if (next_lane_frame)
            next_prbs_q[i] = per_lane_pattern_mode && reg_ph[cpp_pkg::PRBS9_BIT - i];
         next_lane_data[i] = next_prbs_q[i] ? next_lfsr[14] : next_sh[i][SW-1];
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt <= 5'h00;
         sh <= '{default: '0};
         ramp <= '0;
         lfsr <= cpp_pkg::PRBS_SEED;
         prbs_q <= 4'h0;
         lane_data <= 4'h0;
         lane_frame <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         sh <= next_sh;
         ramp <= next_ramp;
         lfsr <= next_lfsr;
         prbs_q <= next_prbs_q;
         lane_data <= next_lane_data;
         lane_frame <= next_lane_frame;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_gain_unity: assert property (sample_valid && global_gain_on && !global_offset_on
      && reg_go[15:11] == 5'h00 |=> s1[3] == $past(sample_ch12)) else $error("unity gain changed data");
   a_gain_max: assert property (sample_valid && global_gain_on && !global_offset_on
      && reg_go[15:11] == 5'h1f && sample_ch12 == SW'('h10) |=> s1[3] == SW'('h20)) else $error("max gain wrong");
   a_gain_gate: assert property (sample_valid && !global_gain_on && !global_offset_on
      |=> s1[3] == $past(sample_ch12)) else $error("gain applied while disabled");
   a_offset_add: assert property (sample_valid && !global_gain_on && global_offset_on
      && sample_ch12[SW-1:SW-2] == 2'h0 |=> s1[3] == $past(sample_ch12) + $past(ofs_sx)) else $error("offset wrong");
   a_hpf_bypass: assert property (v1 && !hpf_on |=> out[3] == $past(s1[3])) else $error("bypass altered data");
   a_k_range: assert property (k_eff >= cpp_pkg::K_MIN && k_eff <= cpp_pkg::K_MAX) else $error("k out of range");
   a_hpf_step: assert property (v1 && hpf_on && xp[3] == 0 && yp[3] == 0 && s1[3] == SW'('h400)
      |=> out[3] > SW'('h300) && out[3] < SW'('h400)) else $error("filter step response wrong");
   a_prbs_gate: assert property (lane_frame && !prbs_q[0] |-> lane_data[0] == sh[0][SW-1]) else $error("lane bit");
   a_pat_zero: assert property (next_lane_frame && per_lane_pattern_mode
      && reg_ph[11:9] == 3'h1 |=> sh[0] == '0) else $error("zero pattern not loaded");
   a_frame_len: assert property (lane_frame |-> ##FL lane_frame) else $error("frame period wrong");
   a_reg_write: assert property (wr && paddr == 8'hac
      |=> reg_go == ($past(pwdata[15:0]) & cpp_pkg::MASK_GAIN_OFS)) else $error("gain register write lost");
   a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready) else $error("apb answer timing");

   c_hpf_run: cover property (v1 && hpf_on ##1 v1);
   c_prbs_lane: cover property (lane_frame && prbs_q[0]);
   c_apb_error: cover property (pready && pslverr);
   c_gain_max: cover property (sample_valid && global_gain_on && reg_go[15:11] == 5'h1f);
endmodule // cpp_chan_postproc

//--- verification/cpp_lane_rx.sv
/*
 Far-side receiver model: deserialises the four lanes, MSB first.
 Assumes lane_data and lane_frame change just after rising mclk.
*/
module cpp_lane_rx #(
   parameter int SW = 14
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [3:0] lane_data,
   input wire logic lane_frame,
   output logic [SW-1:0] rx_word [4],
   output logic word_done,
   output int frame_bad,
   output logic [63:0] lane10_hist
);
   logic [SW-1:0] sh [4];
   int cnt;
   logic synced;
   // ----------------------------------------
   // Deserialiser
   // ----------------------------------------
   // Word framing kept
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt <= 0;
         synced <= 1'b0;
         word_done <= 1'b0;
         frame_bad <= 0;
         lane10_hist <= '0;
         sh <= '{default: '0};
         rx_word <= '{default: '0};
      end
      else
      begin
         word_done <= 1'b0;
         lane10_hist <= {lane10_hist[62:0], lane_data[1]};
         for (int i = 0; i < 4; i++)
            sh[i] <= {sh[i][SW-2:0], lane_data[i]};
         cnt <= lane_frame ? 1 : cnt + 1;
         // Spacing is only judged once the first frame marker was seen
         if (lane_frame && synced && cnt != SW)
            frame_bad <= frame_bad + 1;
         if (lane_frame)
            synced <= 1'b1;
         if (synced && !lane_frame && cnt == SW - 1)
         begin
            word_done <= 1'b1;
            for (int i = 0; i < 4; i++)
               rx_word[i] <= {sh[i][SW-2:0], lane_data[i]};
         end
      end
   end
endmodule // cpp_lane_rx

//--- verification/test_cpp_chan_postproc.sv
/*
 Self-checking bench: APB register checks, datapath and lane patterns.
 Assumes the lane receiver model; APB answers are scored from a queue.
*/
`define CHK(nm, ex, gt) \
   begin \
      total_checks++; \
      if ((gt) !== (ex)) \
      begin \
         $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
         err_total++; \
      end \
   end
module test_cpp_chan_postproc;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] A_GL = {cpp_pkg::IDX_GLOBAL_CFG, 2'b00};
   localparam logic [7:0] A_PM = {cpp_pkg::IDX_PATTERN_CFG, 2'b00};
   localparam logic [7:0] A_GO = {cpp_pkg::IDX_CH12_GAIN_OFS, 2'b00};
   localparam logic [7:0] A_OC = {cpp_pkg::IDX_CH12_OFS_COPY, 2'b00};
   localparam logic [7:0] A_PH = {cpp_pkg::IDX_PAT_HPF, 2'b00};
   localparam logic [7:0] A_ST = {cpp_pkg::IDX_STATUS, 2'b00};
   logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd_last;
   logic pready, pslverr, lane_frame, word_done;
   logic signed [13:0] smp [4] = '{default: '0};
   logic [3:0] lane_data;
   logic [13:0] rx_word [4];
   logic [63:0] lane10_hist;
   logic [33:0] q [$];
   logic [33:0] e;
   int frame_bad, err_total = 0, total_checks = 0;

   cpp_chan_postproc dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .sample_ch9(smp[0]), .sample_ch10(smp[1]), .sample_ch11(smp[2]),
      .sample_ch12(smp[3]), .lane_data(lane_data), .lane_frame(lane_frame));
   cpp_lane_rx rx (.mclk(mclk), .reset_n(reset_n), .lane_data(lane_data), .lane_frame(lane_frame),
      .rx_word(rx_word), .word_done(word_done), .frame_bad(frame_bad), .lane10_hist(lane10_hist));

   initial
      forever #50 mclk = ~mclk;
   initial
   begin
      repeat (90000) @(posedge mclk);
      err_total++;
      summarize();
   end
   // ----------------------------------------
   // Scoreboard and tasks
   // ----------------------------------------
   always @(posedge mclk)
      if (pready === 1'b1)
      begin
         rd_last = prdata;
         e = q.pop_front();
         `CHK("pslverr", e[32], pslverr)
         if (e[33])
            `CHK("prdata", e[31:0], prdata)
      end
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic c, input logic er,
      input logic [31:0] x);
      int n;
      q.push_back({c, er, x});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         err_total++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, d, 1'b0, 1'b0, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 16'h0, 1'b1, 1'b0, x);
   endtask
   task automatic put(input logic signed [13:0] x);
      smp <= '{x, x, x, x};
      sample_valid <= 1'b1;
      @(posedge mclk);
      sample_valid <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   // Waits for completed receiver words; a stalled lane ends the run
   task automatic words(input int n);
      int t;
      t = 0;
      while (n > 0 && t < 1000)
      begin
         @(posedge mclk);
         t++;
         if (word_done === 1'b1)
            n--;
      end
      if (n > 0)
      begin
         err_total++;
         summarize();
      end
   endtask
   function automatic int sat(input int v);
      return v > 8191 ? 8191 : (v < -8192 ? -8192 : v);
   endfunction
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      int x, n, o, lo;
      logic [13:0] ex, w;
      logic pb;
      int kv [2] = '{10, 2};
      void'($urandom(32'h5b6a0be6));
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rd(A_GO, 32'h0);
      rd(A_OC, 32'h0);
      rd(A_PH, 32'h0);
      // Every writable bit set; reserved bits kept zero and k kept legal
      wr(A_GO, 16'hfbff);
      rd(A_GO, 32'hfbff);
      wr(A_PH, 16'hffd5);
      rd(A_PH, 32'hffd5);
      wr(A_PH, 16'h0);
      apb(1'b0, 8'h00, 16'h0, 1'b1, 1'b1, 32'h0);
      apb(1'b1, A_GO | 8'h01, 16'h0, 1'b0, 1'b1, 32'h0);
      x = $urandom_range(16383) - 8192;
      put(x);
      rd(A_ST, {18'h0, x[13:0]});
      for (int i = 0; i < 8; i++)
      begin
         x = (i == 5) ? 16 : $urandom_range(16383) - 8192;
         n = (i == 5 || i == 7) ? 31 : $urandom_range(31);
         o = $urandom_range(1023);
         o = o > 511 ? o - 1024 : o;
         wr(A_GL, {3'h0, i[0], 3'h0, i[1], 8'h0});
         wr(A_GO, {n[4:0], 1'b0, o[9:0]});
         wr(A_OC, {6'h0, o[9:0]});
         put(x);
         lo = i[0] ? (x * int'(cpp_pkg::GAIN_Q10[n])) >>> 10 : x;
         lo = sat(lo + (i[1] ? o : 0));
         ex = lo[13:0];
         rd(A_ST, {18'h0, ex});
         words(2);
         `CHK("lane12 word", ex, rx_word[3])
      end
      wr(A_GL, 16'h0);
      foreach (kv[j])
      begin
         wr(A_PH, 16'h0);
         put(0);
         wr(A_PH, {11'h0, kv[j][3:0], 1'b1});
         put(1024);
         apb(1'b0, A_ST, 16'h0, 1'b0, 1'b0, 32'h0);
         lo = (kv[j] == 2) ? 810 : 1015;
         `CHK("hpf step", 1'b1, rd_last >= lo && rd_last < 1024)
      end
      repeat (50) put(1000);
      rd(A_ST, 32'h0);
      wr(A_PH, 16'hc400);
      put(5);
      words(3);
      `CHK("mode off lane9", 14'h5, rx_word[0])
      wr(A_PM, 16'h0100);
      for (int c = 1; c < 5; c++)
      begin
         wr(A_PH, {4'h4, c[2:0], 9'h0});
         words(2);
         w = rx_word[0];
         words(1);
         ex = c == 1 ? 14'h0 : c == 2 ? 14'h3fff : c == 3 ? ~w : w + 14'h1;
         `CHK("lane9 pattern", ex, c < 3 ? w : rx_word[0])
      end
      words(6);
      pb = 1'b0;
      for (int i = 0; i < 49; i++)
         if (lane10_hist[i] !== (lane10_hist[i+14] ^ lane10_hist[i+15]))
            pb = 1'b1;
      `CHK("lane10 prbs", 1'b0, pb)
      `CHK("lane10 prbs live", 1'b1, |lane10_hist)
      wr(A_PH, {7'h0, 3'h2, 6'h0});
      words(2);
      `CHK("lane10 pattern", 14'h3fff, rx_word[1])
      `CHK("frame spacing", 0, frame_bad)
      summarize();
   end
endmodule // test_cpp_chan_postproc
